/* File: inc/acl_pkg.sv */
// package of constants for the ascii checksum command link host
// assumes a single 125 MHz clock and a 9600 baud 8N1 serial line
package acl_pkg;
	localparam int CLK_HZ = 125000000;
	localparam int BAUD = 9600;
	localparam int BIT_CYC = CLK_HZ / BAUD;
	localparam int GAP_US = 1000;
	localparam int GAP_CYC = (CLK_HZ / 1000000) * GAP_US;
	localparam logic [7:0] CH_START = 8'h2A;
	localparam logic [7:0] CH_CR = 8'h0D;
	localparam logic [7:0] CH_ACK = 8'h5E;
	localparam logic [7:0] CH_X = 8'h58;
	localparam logic [7:0] CH_ZERO = 8'h30;
	localparam logic [7:0] ERR_SUM = 8'hC0;
	localparam logic [7:0] OWN_ADDR = 8'h00;
	localparam int REPLY_LEN = 11;
	localparam int TX_LEN = 16;

	// nibble to lowercase ascii hex
	function automatic logic [7:0] acl_hex(input logic [3:0] n);
		return (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
	endfunction

	// lowercase ascii hex to nibble, bit 4 flags a bad digit
	function automatic logic [4:0] acl_nib(input logic [7:0] c);
		if (c >= 8'h30 && c <= 8'h39)
			return {1'b0, c[3:0]};
		else if (c >= 8'h61 && c <= 8'h66)
			return {1'b0, c[3:0] + 4'h9};
		else
			return 5'h10;
	endfunction
endpackage

/* File: inc/acl_stream_if.sv */
// byte stream carrier between the host engine and its reply buffer
// assumes one clock shared by both ends
`timescale 1ns/1ns
interface acl_stream_if;
	logic valid;
	logic ready;
	logic [7:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface

/* File: rtl/acl_host.sv */
// host end of the ascii checksum command link: builds frames, checks replies
// assumes 125 MHz mclk, a serial pin pair to the device, no flow control
`timescale 1ns/1ns
module acl_host #(
	parameter int GAP_CYCLES = acl_pkg::GAP_CYC,
	parameter int BIT_CYCLES = acl_pkg::BIT_CYC
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// command request
	input wire logic cmd_valid,
	input wire logic cmd_query,
	input wire logic [7:0] cmd_code,
	input wire logic [31:0] cmd_value,
	output logic cmd_ready,
	// reply result
	output logic rsp_valid,
	output logic rsp_ok,
	output logic rsp_dev_err,
	output logic [31:0] rsp_value,
	// serial pins
	output logic ser_txd,
	input wire logic ser_rxd
);
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_SEND = 4'b0010,
		ST_GAP = 4'b0100,
		ST_WAIT = 4'b1000
	} acl_st_e;

	acl_st_e st_r, st_nxt;
	logic [7:0] txf_r [acl_pkg::TX_LEN];
	logic [7:0] txf_nxt [acl_pkg::TX_LEN];
	logic [4:0] tidx_r, tidx_nxt;
	logic [31:0] gap_r, gap_nxt;
	logic [15:0] tbd_r, tbd_nxt;
	logic [3:0] tbit_r, tbit_nxt;
	logic [9:0] tsh_r, tsh_nxt;
	logic txd_r, txd_nxt;
	logic tbusy;
	logic [7:0] sum;
	logic rsp_nxt_v;

	// tx frame assembly, ascii checksum over address, command and value
	always_comb begin
		txf_nxt = txf_r;
		sum = 8'h00;
		txf_nxt[0] = acl_pkg::CH_START;
		txf_nxt[1] = acl_pkg::acl_hex(acl_pkg::OWN_ADDR[7:4]);
		txf_nxt[2] = acl_pkg::acl_hex(acl_pkg::OWN_ADDR[3:0]);
		txf_nxt[3] = acl_pkg::acl_hex(cmd_code[7:4]);
		txf_nxt[4] = acl_pkg::acl_hex(cmd_code[3:0]);
		for (int i = 0; i < 8; i++)
			txf_nxt[5+i] = cmd_query ? acl_pkg::CH_ZERO :
				acl_pkg::acl_hex(cmd_value[31-4*i -: 4]);
		for (int i = 1; i < 13; i++)
			sum = sum + txf_nxt[i];
		txf_nxt[13] = acl_pkg::acl_hex(sum[7:4]);
		txf_nxt[14] = acl_pkg::acl_hex(sum[3:0]);
		txf_nxt[15] = acl_pkg::CH_CR;
		if (!(st_r == ST_IDLE && cmd_valid))
			txf_nxt = txf_r;
	end

	// sequencer and 8N1 transmitter with character gap
	always_comb begin
		st_nxt = st_r;
		tidx_nxt = tidx_r;
		gap_nxt = gap_r;
		tbd_nxt = tbd_r;
		tbit_nxt = tbit_r;
		tsh_nxt = tsh_r;
		txd_nxt = txd_r;
		tbusy = (tbit_r != 4'd0);
		if (tbusy) begin
			if (tbd_r == 16'd0) begin
				tbd_nxt = 16'(BIT_CYCLES - 1);
				txd_nxt = tsh_r[0];
				tsh_nxt = {1'b1, tsh_r[9:1]};
				tbit_nxt = tbit_r - 4'd1;
			end else
				tbd_nxt = tbd_r - 16'd1;
		end
		case (st_r)
			ST_IDLE: if (cmd_valid) begin
				st_nxt = ST_SEND;
				tidx_nxt = 5'd0;
			end
			ST_SEND: if (!tbusy) begin
				tsh_nxt = {1'b1, txf_r[tidx_r[3:0]], 1'b0};
				tbit_nxt = 4'd11;
				tbd_nxt = 16'd0;
				gap_nxt = 32'(GAP_CYCLES);
				st_nxt = ST_GAP;
			end
			ST_GAP: if (!tbusy) begin
				if (gap_r != 32'd0)
					gap_nxt = gap_r - 32'd1;
				else if (tidx_r == 5'(acl_pkg::TX_LEN - 1))
					st_nxt = ST_WAIT;
				else begin
					tidx_nxt = tidx_r + 5'd1;
					st_nxt = ST_SEND;
				end
			end
			ST_WAIT: if (rsp_nxt_v)
				st_nxt = ST_IDLE;
			default: st_nxt = ST_IDLE;
		endcase
	end

	// receiver: three-flop sync, 8N1 sampler at mid bit
	logic rx1_r, rx2_r, rx3_r, rxs_r, rxs_nxt;
	logic [15:0] rbd_r, rbd_nxt;
	logic [3:0] rbit_r, rbit_nxt;
	logic [7:0] rsh_r, rsh_nxt;
	acl_stream_if rxs ();
	acl_stream_if chk ();
	logic rv_r, rv_nxt;

	always_comb begin
		rxs_nxt = (rx2_r == rx3_r) ? rx3_r : rxs_r;
		rbd_nxt = rbd_r;
		rbit_nxt = rbit_r;
		rsh_nxt = rsh_r;
		rv_nxt = rv_r && !rxs.ready;
		if (rbit_r == 4'd0) begin
			if (!rxs_r) begin
				rbit_nxt = 4'd10;
				rbd_nxt = 16'(BIT_CYCLES / 2);
			end
		end else if (rbd_r != 16'd0)
			rbd_nxt = rbd_r - 16'd1;
		else begin
			rbd_nxt = 16'(BIT_CYCLES - 1);
			rbit_nxt = rbit_r - 4'd1;
			if (rbit_r == 4'd10 && rxs_r)
				rbit_nxt = 4'd0;
			else if (rbit_r != 4'd1 && rbit_r != 4'd10)
				rsh_nxt = {rxs_r, rsh_r[7:1]};
			else if (rbit_r == 4'd1)
				rv_nxt = 1'b1;
		end
	end
	assign rxs.valid = rv_r;
	assign rxs.data = rsh_r;

	acl_skid #(.WIDTH(8)) u_skid (
		.mclk(mclk),
		.rst(rst),
		.up(rxs.snk),
		.dn(chk.src)
	);

	// reply checker: collect up to ten characters after start, await caret
	logic [7:0] rf_r [10];
	logic [7:0] rf_nxt [10];
	logic [3:0] rcnt_r, rcnt_nxt;
	logic rok_nxt, rerr_nxt;
	logic [31:0] rval_nxt;
	logic [7:0] rsum;
	logic bad;
	logic [4:0] nb;
	assign chk.ready = 1'b1;

	always_comb begin
		rf_nxt = rf_r;
		rcnt_nxt = rcnt_r;
		rsp_nxt_v = 1'b0;
		rok_nxt = 1'b0;
		rerr_nxt = 1'b0;
		rval_nxt = rsp_value;
		rsum = 8'h00;
		bad = 1'b0;
		nb = 5'h00;
		for (int i = 0; i < 8; i++) begin
			rsum = rsum + rf_r[i];
			nb = acl_pkg::acl_nib(rf_r[i]);
			bad = bad | nb[4];
			rval_nxt[31-4*i -: 4] = nb[3:0];
		end
		if (chk.valid) begin
			if (chk.data == acl_pkg::CH_START)
				rcnt_nxt = 4'd1;
			else if (chk.data == acl_pkg::CH_ACK && rcnt_r != 4'd0) begin
				rcnt_nxt = 4'd0;
				if (st_r == ST_WAIT) begin
					rsp_nxt_v = 1'b1;
					rerr_nxt = (rcnt_r == 4'd11) &&
						(rf_r[0] == acl_pkg::CH_X);
					rok_nxt = (rcnt_r == 4'd11) && !bad &&
						(rf_r[8] == acl_pkg::acl_hex(rsum[7:4])) &&
						(rf_r[9] == acl_pkg::acl_hex(rsum[3:0]));
				end
			end else if (rcnt_r != 4'd0 && rcnt_r != 4'd11) begin
				rf_nxt[rcnt_r - 4'd1] = chk.data;
				rcnt_nxt = rcnt_r + 4'd1;
			end
		end
		if (!rok_nxt)
			rval_nxt = rsp_value;
	end

	// registers
	always_ff @(posedge mclk) begin
		txf_r <= txf_nxt;
		rf_r <= rf_nxt;
		if (rst) begin
			st_r <= ST_IDLE;
			// sync chain preset to idle high, no false start bit
			rx1_r <= 1'b1;
			rx2_r <= 1'b1;
			rx3_r <= 1'b1;
			tidx_r <= 5'd0;
			gap_r <= 32'd0;
			tbd_r <= 16'd0;
			tbit_r <= 4'd0;
			tsh_r <= 10'h3FF;
			txd_r <= 1'b1;
			rxs_r <= 1'b1;
			rbd_r <= 16'd0;
			rbit_r <= 4'd0;
			rsh_r <= 8'h00;
			rv_r <= 1'b0;
			rcnt_r <= 4'd0;
			rsp_valid <= 1'b0;
			rsp_ok <= 1'b0;
			rsp_dev_err <= 1'b0;
			rsp_value <= 32'h0;
			cmd_ready <= 1'b0;
		end else begin
			st_r <= st_nxt;
			rx1_r <= ser_rxd;
			rx2_r <= rx1_r;
			rx3_r <= rx2_r;
			tidx_r <= tidx_nxt;
			gap_r <= gap_nxt;
			tbd_r <= tbd_nxt;
			tbit_r <= tbit_nxt;
			tsh_r <= tsh_nxt;
			txd_r <= txd_nxt;
			rxs_r <= rxs_nxt;
			rbd_r <= rbd_nxt;
			rbit_r <= rbit_nxt;
			rsh_r <= rsh_nxt;
			rv_r <= rv_nxt;
			rcnt_r <= rcnt_nxt;
			rsp_valid <= rsp_nxt_v;
			rsp_ok <= rok_nxt;
			rsp_dev_err <= rerr_nxt;
			rsp_value <= rval_nxt;
			cmd_ready <= (st_nxt == ST_IDLE);
		end
	end
	assign ser_txd = txd_r;

	AST_START_FIRST: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_IDLE && cmd_valid) |=> (txf_r[0] == 8'h2A))
		else $error("frame does not open with start");
	AST_CR_LAST: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_IDLE && cmd_valid) |=> (txf_r[15] == 8'h0D))
		else $error("frame does not end with carriage return");
	AST_ADDR_ZERO: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_IDLE && cmd_valid) |=>
		(txf_r[1] == 8'h30 && txf_r[2] == 8'h30))
		else $error("address not 00");
	AST_QUERY_ZEROS: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_IDLE && cmd_valid && cmd_query) |=>
		(txf_r[5] == 8'h30 && txf_r[12] == 8'h30))
		else $error("query value not zeros");
	AST_IDLE_HIGH: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_IDLE && tbit_r == 4'd0) |-> ser_txd)
		else $error("line not idle high");
	AST_START_BIT: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_SEND && tbit_r == 4'd0) |-> ##2 (tbit_r == 4'd10))
		else $error("start bit not launched");
	AST_OK_EXCL: assert property (@(posedge mclk) disable iff (rst)
		rsp_ok |-> (rsp_valid && !rsp_dev_err))
		else $error("ok without valid reply");
	AST_GAP_LOAD: assert property (@(posedge mclk) disable iff (rst)
		(st_r == ST_SEND && tbit_r == 4'd0) |=> (st_r == ST_GAP))
		else $error("no gap after character");
endmodule // acl_host

/* File: rtl/acl_skid.sv */
// two-entry buffer between received reply bytes and the frame checker
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ns
module acl_skid #(
	parameter int WIDTH = 8
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst,
	// stream ports
	acl_stream_if.snk up,
	acl_stream_if.src dn
);
	logic [WIDTH-1:0] mem_r [2];
	logic [WIDTH-1:0] mem_nxt [2];
	logic [1:0] cnt_r, cnt_nxt;
	logic rd_r, rd_nxt, wr_r, wr_nxt;
	logic push, pop;

	// occupancy and pointer updates
	always_comb begin
		push = up.valid && (cnt_r != 2'd2);
		pop = dn.ready && (cnt_r != 2'd0);
		mem_nxt = mem_r;
		wr_nxt = wr_r;
		rd_nxt = rd_r;
		cnt_nxt = cnt_r;
		if (push) begin
			mem_nxt[wr_r] = up.data[WIDTH-1:0];
			wr_nxt = ~wr_r;
		end
		if (pop)
			rd_nxt = ~rd_r;
		if (push && !pop)
			cnt_nxt = cnt_r + 2'd1;
		else if (pop && !push)
			cnt_nxt = cnt_r - 2'd1;
	end

	// state registers
	always_ff @(posedge mclk) begin
		if (rst) begin
			cnt_r <= 2'd0;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			rd_r <= rd_nxt;
			wr_r <= wr_nxt;
		end
		mem_r <= mem_nxt;
	end

	assign up.ready = (cnt_r != 2'd2);
	assign dn.valid = (cnt_r != 2'd0);
	assign dn.data = mem_r[rd_r];

	AST_NO_OVERFLOW: assert property (@(posedge mclk) disable iff (rst)
		cnt_r <= 2'd2) else $error("buffer count above two");
endmodule // acl_skid

/* File: sim/acl_dev_model.sv */
// behavioural model of the addressed device on the serial pair
// assumes 8N1 framing at BIT_NS per bit, idle line high
`timescale 1ns/1ns
module acl_dev_model #(
	parameter int BIT_NS = 128
) (
	// serial pins
	input wire logic rxd,
	output logic txd,
	// fault choice: 0 good, 1 bad reply sum, 2 error reply
	input wire logic [1:0] mode
);
	logic [7:0] rx [0:15];
	logic [31:0] mem [0:255];
	int n;
	// nibble to lowercase hex character
	function automatic logic [7:0] hx(input logic [3:0] v);
		return (v < 4'hA) ? 8'h30 + v : 8'h57 + v;
	endfunction
	// lowercase hex character to nibble
	function automatic logic [3:0] nb(input logic [7:0] c);
		return (c > 8'h39) ? c[3:0] + 4'h9 : c[3:0];
	endfunction
	// one 8N1 character, lsb first
	task automatic put(input logic [7:0] c);
		txd = 1'b0;
		#(BIT_NS);
		for (int i = 0; i < 8; i++) begin
			txd = c[i];
			#(BIT_NS);
		end
		txd = 1'b1;
		#(BIT_NS);
	endtask
	// receive characters, assemble frames, answer on carriage return
	initial begin
		logic [7:0] c, s;
		logic [31:0] v, r;
		logic [7:0] rep [0:11];
		txd = 1'b1;
		n = 0;
		forever begin
			@(negedge rxd);
			#(BIT_NS * 3 / 2);
			for (int i = 0; i < 8; i++) begin
				c[i] = rxd;
				#(BIT_NS);
			end
			if (c == 8'h2A) begin
				n = 0;
			end else if (c != 8'h0D) begin
				if (n < 16)
					rx[n] = c;
				n++;
			end else if (rx[0] == 8'h30 && rx[1] == 8'h30) begin
				s = 8'h00;
				v = 32'h0;
				for (int i = 0; i < 12; i++)
					s += rx[i];
				for (int i = 4; i < 12; i++)
					v = {v[27:0], nb(rx[i])};
				r = (v == 32'h0) ? mem[{nb(rx[2]), nb(rx[3])}] : v;
				if (v != 32'h0)
					mem[{nb(rx[2]), nb(rx[3])}] = v;
				rep[0] = 8'h2A;
				rep[11] = 8'h5E;
				s = (n != 14 || mode == 2'h2) ? 8'h01 : s - {nb(rx[12]), nb(rx[13])};
				for (int i = 0; i < 8; i++)
					rep[1 + i] = (s != 8'h00) ? 8'h58 : hx(r[31 - 4 * i -: 4]);
				s = 8'h00;
				for (int i = 1; i < 9; i++)
					s += rep[i];
				s = (mode == 2'h1) ? s ^ 8'h01 : s;
				rep[9] = hx(s[7:4]);
				rep[10] = hx(s[3:0]);
				for (int i = 0; i < 12; i++)
					put(rep[i]);
			end
		end
	end
endmodule // acl_dev_model

/* File: sim/testbench.sv */
// self-checking bench: host engine against the device model
// assumes shortened bit and gap counts for simulation
`timescale 1ns/1ns
module testbench;
	logic mclk, rst, cmd_valid, cmd_query, cmd_ready, rsp_valid, rsp_ok;
	logic rsp_dev_err, ser_txd, ser_rxd;
	logic [7:0] cmd_code;
	logic [31:0] cmd_value, rsp_value;
	logic [1:0] mode;
	int fail_count, n_tests;
	acl_host #(.GAP_CYCLES(10), .BIT_CYCLES(16)) uut (.mclk(mclk), .rst(rst),
		.cmd_valid(cmd_valid), .cmd_query(cmd_query), .cmd_code(cmd_code),
		.cmd_value(cmd_value), .cmd_ready(cmd_ready), .rsp_valid(rsp_valid),
		.rsp_ok(rsp_ok), .rsp_dev_err(rsp_dev_err), .rsp_value(rsp_value),
		.ser_txd(ser_txd), .ser_rxd(ser_rxd));
	acl_dev_model #(.BIT_NS(128)) dev (.rxd(ser_txd), .txd(ser_rxd),
		.mode(mode));
	// 125 MHz clock
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	// compare and count
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %0t saw %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// one request, waits for the reply pulse
	task automatic run(input logic q, input logic [7:0] c, input logic [31:0] v);
		int k;
		k = 0;
		while (cmd_ready !== 1'b1 && k < 100) begin
			@(posedge mclk);
			#1;
			k++;
		end
		if (cmd_ready !== 1'b1) begin
			fail_count++;
			$display("[FAIL] %0t never ready", $time);
			report_and_stop();
		end
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_query <= q;
		cmd_code <= c;
		cmd_value <= v;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		@(posedge mclk);
		#1;
		chk(cmd_ready, 1'b0);
		k = 0;
		do begin
			@(posedge mclk);
			#1;
			k++;
		end while (rsp_valid !== 1'b1 && k < 20000);
		if (k >= 20000) begin
			fail_count++;
			$display("[FAIL] %0t no reply", $time);
			report_and_stop();
		end
		chk(cmd_ready, 1'b1);
	endtask
	// write of a negative value, frame contents seen by the device
	task automatic t_write();
		run(1'b0, 8'h1C, 32'hFFFFFF6A);
		chk(rsp_ok, 1'b1);
		chk(rsp_dev_err, 1'b0);
		chk(rsp_value, 32'hFFFFFF6A);
		chk({dev.rx[0], dev.rx[1]}, 32'h3030);
		chk({dev.rx[2], dev.rx[3]}, 32'h3163);
		chk({dev.rx[4], dev.rx[5], dev.rx[6], dev.rx[7]}, 32'h66666666);
		chk({dev.rx[12], dev.rx[13]}, 32'h6566);
		chk(dev.n, 14);
	endtask
	// query returns the stored value, zeros in the value field
	task automatic t_query();
		run(1'b1, 8'h1C, 32'h12345678);
		chk({dev.rx[4], dev.rx[5], dev.rx[6], dev.rx[7]}, 32'h30303030);
		chk({dev.rx[8], dev.rx[9], dev.rx[10], dev.rx[11]}, 32'h30303030);
		chk(rsp_ok, 1'b1);
		chk(rsp_value, 32'hFFFFFF6A);
	endtask
	// corrupted reply checksum is refused, value kept
	task automatic t_badsum();
		mode <= 2'h1;
		run(1'b0, 8'h29, 32'h00000001);
		chk(rsp_ok, 1'b0);
		chk(rsp_value, 32'hFFFFFF6A);
	endtask
	// device error reply
	task automatic t_deverr();
		mode <= 2'h2;
		run(1'b1, 8'h01, 32'h0);
		chk(rsp_dev_err, 1'b1);
		chk(rsp_ok, 1'b0);
	endtask
	// reset cuts a frame; a fresh query is then answered in full
	task automatic t_reset();
		mode <= 2'h0;
		@(posedge mclk);
		cmd_valid <= 1'b1;
		cmd_query <= 1'b1;
		cmd_code <= 8'h1C;
		@(posedge mclk);
		cmd_valid <= 1'b0;
		repeat (400) @(posedge mclk);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		chk(ser_txd, 1'b1);
		chk(cmd_ready, 1'b0);
		@(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk(cmd_ready, 1'b1);
		chk(rsp_value, 32'h0);
		repeat (200) @(posedge mclk);
		run(1'b1, 8'h1C, 32'h0);
		chk(rsp_ok, 1'b1);
		chk(rsp_value, 32'hFFFFFF6A);
	endtask
	// main sequence
	initial begin
		rst = 1'b1;
		cmd_valid = 1'b0;
		cmd_query = 1'b0;
		cmd_code = 8'h00;
		cmd_value = 32'h0;
		mode = 2'h0;
		fail_count = 0;
		n_tests = 0;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		#1;
		chk(ser_txd, 1'b1);
		t_write();
		t_query();
		t_badsum();
		t_deverr();
		t_reset();
		report_and_stop();
	end
endmodule // testbench
